// *** design/sspm_map.svh ***
`ifndef SSPM_MAP_SVH
`define SSPM_MAP_SVH

// register offsets (byte addresses on apb)
`define SSPM_CTRL_OFS     12'h000
`define SSPM_STAT_OFS     12'h004
`define SSPM_BUF_OFS      12'h008
`define SSPM_PER_OFS      12'h00C
`define SSPM_ISTAT_OFS    12'h010
`define SSPM_IMASK_OFS    12'h014

// field layouts and reset values
`define SSPM_CTRL_W       7
`define SSPM_CTRL_RST     7'h00
`define SSPM_PER_RST      8'h00
`define SSPM_IRQ_W        2
`define SSPM_IRQ_DONE     0
`define SSPM_IRQ_COLL     1

// bit-rate select codes
`define SSPM_RATE_DIV4    2'h0
`define SSPM_RATE_DIV16   2'h1
`define SSPM_RATE_DIV64   2'h2
`define SSPM_RATE_TMR     2'h3

// half bit periods in oscillator cycles
`define SSPM_HALF_DIV4    6'h02
`define SSPM_HALF_DIV16   6'h08
`define SSPM_HALF_DIV64   6'h20

// period timer counts instruction cycles of four oscillator cycles
`define SSPM_PRESC_LAST   2'h3

// reference point of the fastest rate
`define SSPM_REF_FOSC_HZ  20000000
`define SSPM_REF_RATE_BPS 5000000

`endif

// *** design/sspm_pkg.sv ***
package sspm_pkg;

    // control register layout, msb first
    typedef struct packed {
        logic       sdo_en;
        logic       input_sample_phase;
        logic       edge_sel;
        logic       clock_idle_polarity;
        logic [1:0] rate;
        logic       en;
    } sspm_ctrl_s;

    // serial pins driven by the master
    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdo_oe;
    } sspm_pins_s;

    typedef enum logic {
        SSPM_IDLE,
        SSPM_RUN
    } sspm_state_e;

endpackage : sspm_pkg

// *** design/sspm_top.sv ***
// Function
// - writing a byte into the transfer buffer starts the shift at once.
// - with the data output disabled the input is still shifted in at rate.
// - bit clock is osc/4, osc/16, osc/64 or period timer output/2.
// - the fastest rate gives 5 Mbps from a 20 MHz oscillator.
// - sck is an output whose idle level follows clock_idle_polarity.
// - edge select set puts each data bit out before its sck edge.
// - input is sampled mid bit or at end of bit per input_sample_phase.
// - in sleep every port clock stops and the transfer freezes in place.
// - after wake the transfer resumes from the bit where it stopped.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sspm_map.svh"

module sspm_top #(
    parameter int BITS = 8
) (
    // apb slave
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // serial pins
    output sspm_pkg::sspm_pins_s     spi_out,
    input  wire logic                sdi,
    // power state and interrupt
    input  wire logic                sleep_req,
    output logic                     irq
);
    import sspm_pkg::*;

    localparam int        CW    = $clog2(2 * BITS + 1);
    localparam logic [CW-1:0] LAST = CW'(2 * BITS);

    // bit count must fit the shifters and the data bus
    if (BITS < 2 || BITS > 16)
    begin : g_bits_chk
        $error("sspm_top: BITS must lie in 2..16");
    end
    // fastest divider must equal the reference rate ratio
    if (`SSPM_REF_FOSC_HZ / `SSPM_REF_RATE_BPS
        != 2 * int'(`SSPM_HALF_DIV4))
    begin : g_rate_chk
        $error("sspm_top: fastest divider does not match reference");
    end

    sspm_ctrl_s               ctrl_r;
    sspm_state_e              state_r;
    logic [7:0]               period_r;
    logic [BITS-1:0]          rxbuf_r;
    logic [BITS-1:0]          tx_sh_r;
    logic [BITS-1:0]          serial_shift_register_r;
    logic [BITS-1:0]          ssr_nxt;
    logic                     bf_r;
    logic [`SSPM_IRQ_W-1:0]   istat_r;
    logic [`SSPM_IRQ_W-1:0]   imask_r;
    logic [CW-1:0]            tick_r;
    logic [5:0]               half_cnt_r;
    logic [5:0]               half_lim;
    logic [1:0]               presc_r;
    logic [7:0]               tmr_r;
    logic                     sdi_s1_r;
    logic                     sdi_s2_r;
    logic                     slp_s1_r;
    logic                     slp_s2_r;
    logic [1:0]               samp_dly_r;

    logic                     run_en;
    logic                     busy;
    logic                     acc;
    logic                     wr_fire;
    logic                     rd_fire;
    logic                     mapped;
    logic [31:0]              rd_val;
    logic                     buf_wr;
    logic                     start;
    logic                     coll;
    logic                     tmr_match;
    logic                     half_tick;
    logic                     toggle;
    logic                     shift_out;
    logic                     sample;
    logic                     done;
    logic                     odd_k;

    // pin inputs pass two flops before any logic reads them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
            slp_s1_r <= 1'b0;
            slp_s2_r <= 1'b0;
            samp_dly_r <= 2'h0;
        end
        else
        begin
            sdi_s1_r <= sdi;
            sdi_s2_r <= sdi_s1_r;
            slp_s1_r <= sleep_req;
            slp_s2_r <= slp_s1_r;
            samp_dly_r <= {samp_dly_r[0], sample && (tick_r != LAST)};
        end
    end

    // sleep halts every clock of the port, state stays put
    assign run_en = ~slp_s2_r;
    assign busy   = (state_r == SSPM_RUN);

    // apb: one wait state, effects land on the pready edge
    assign acc     = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite;
    assign rd_fire = psel & penable & pready & ~pwrite;

    // register read mux and address decode
    always_comb
    begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            `SSPM_CTRL_OFS:  rd_val[`SSPM_CTRL_W-1:0] = ctrl_r;
            `SSPM_STAT_OFS:  rd_val[2:0] = {slp_s2_r, busy, bf_r};
            `SSPM_BUF_OFS:   rd_val[BITS-1:0] = rxbuf_r;
            `SSPM_PER_OFS:   rd_val[7:0] = period_r;
            `SSPM_ISTAT_OFS: rd_val[`SSPM_IRQ_W-1:0] = istat_r;
            `SSPM_IMASK_OFS: rd_val[`SSPM_IRQ_W-1:0] = imask_r;
            default:         mapped = 1'b0;
        endcase
    end

    // answer flops: data and error are valid with pready only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            prdata  <= (acc && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    // writable configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= sspm_ctrl_s'(`SSPM_CTRL_RST);
            period_r <= `SSPM_PER_RST;
            imask_r  <= '0;
        end
        else if (wr_fire)
        begin
            if (paddr == `SSPM_CTRL_OFS)
                ctrl_r <= sspm_ctrl_s'(pwdata[`SSPM_CTRL_W-1:0]);
            if (paddr == `SSPM_PER_OFS)
                period_r <= pwdata[7:0];
            if (paddr == `SSPM_IMASK_OFS)
                imask_r <= pwdata[`SSPM_IRQ_W-1:0];
        end
    end

    // a buffer write starts a transfer, no separate go bit
    assign buf_wr = wr_fire && (paddr == `SSPM_BUF_OFS);
    assign start  = buf_wr & ctrl_r.en & ~busy;
    // a write while shifting is dropped and flagged
    assign coll   = buf_wr & busy;

    // period timer counts instruction cycles, rolls at period
    assign tmr_match = (presc_r == `SSPM_PRESC_LAST)
                     && (tmr_r == period_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_r <= 2'h0;
            tmr_r   <= 8'h00;
        end
        else if (!ctrl_r.en || ctrl_r.rate != `SSPM_RATE_TMR)
        begin
            presc_r <= 2'h0;
            tmr_r   <= 8'h00;
        end
        else if (run_en)
        begin
            presc_r <= presc_r + 2'h1;
            if (presc_r == `SSPM_PRESC_LAST)
                tmr_r <= tmr_match ? 8'h00 : tmr_r + 8'h01;
        end
    end

    // half bit length; fixed dividers give osc/4, /16, /64
    always_comb
    begin
        unique case (ctrl_r.rate)
            `SSPM_RATE_DIV4:  half_lim = `SSPM_HALF_DIV4;
            `SSPM_RATE_DIV16: half_lim = `SSPM_HALF_DIV16;
            `SSPM_RATE_DIV64: half_lim = `SSPM_HALF_DIV64;
            default:          half_lim = `SSPM_HALF_DIV4;
        endcase
    end

    // half bit enable; timer rate halves the timer match rate
    assign half_tick = busy & run_en
                     & ((ctrl_r.rate == `SSPM_RATE_TMR)
                        ? tmr_match
                        : (half_cnt_r == half_lim - 6'h01));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_cnt_r <= 6'h00;
        else if (start || half_tick)
            half_cnt_r <= 6'h00;
        else if (busy && run_en)
            half_cnt_r <= half_cnt_r + 6'h01;
    end

    // half bit k: sck toggles on k < 2*BITS, k = 2*BITS ends it
    assign odd_k  = tick_r[0];
    assign toggle = half_tick && (tick_r < LAST);
    assign done   = half_tick && (tick_r == LAST);

    // edge set: bit changes on return to idle, ahead of its edge
    // edge clear: bit changes on the edge leaving idle
    assign shift_out = half_tick
        && (ctrl_r.edge_sel
            ? (odd_k && tick_r < LAST - CW'(1))
            : (!odd_k && tick_r != '0 && tick_r < LAST));

    // mid-bit sample sits on the transferring edge, end one half later
    assign sample = half_tick
        && (ctrl_r.input_sample_phase
            ? (ctrl_r.edge_sel ? (odd_k && tick_r < LAST)
                               : (!odd_k && tick_r != '0))
            : (ctrl_r.edge_sel ? (!odd_k && tick_r < LAST)
                               : (odd_k && tick_r < LAST)));

    // input shifts regardless of the data output enable; a sample before k = 2*BITS waits
    // out the two flop lag so it sees the pin as it was at its sck edge
    assign ssr_nxt = (samp_dly_r[1] || (sample && tick_r == LAST))
        ? {serial_shift_register_r[BITS-2:0], sdi_s2_r}
        : serial_shift_register_r;

    // transfer sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= SSPM_IDLE;
            tick_r  <= '0;
        end
        else if (start)
        begin
            state_r <= SSPM_RUN;
            tick_r  <= '0;
        end
        else if (done)
        begin
            state_r <= SSPM_IDLE;
            tick_r  <= '0;
        end
        else if (half_tick) // frozen while asleep
            tick_r <= tick_r + CW'(1);
    end

    // shift registers keep their bits across sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_sh_r                 <= '0;
            serial_shift_register_r <= '0;
        end
        else if (start)
        begin
            tx_sh_r                 <= pwdata[BITS-1:0];
            serial_shift_register_r <= '0;
        end
        else
        begin
            if (shift_out)
                tx_sh_r <= {tx_sh_r[BITS-2:0], 1'b0};
            serial_shift_register_r <= ssr_nxt;
        end
    end

    // pins; sck rests at the idle level whenever no byte is moving
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spi_out <= '0;
        end
        else
        begin
            spi_out.sdo_oe <= ctrl_r.en & ctrl_r.sdo_en;
            if (!busy || done)
                spi_out.sck <= ctrl_r.clock_idle_polarity;
            else if (toggle)
                spi_out.sck <= ~spi_out.sck;
            if (start)
                spi_out.sdo <= pwdata[BITS-1];
            else if (shift_out)
                spi_out.sdo <= tx_sh_r[BITS-2];
        end
    end

    // received byte lands in the buffer; set beats a same-cycle read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxbuf_r <= '0;
            bf_r    <= 1'b0;
        end
        else if (done)
        begin
            rxbuf_r <= ssr_nxt;
            bf_r    <= 1'b1;
        end
        else if (rd_fire && paddr == `SSPM_BUF_OFS)
            bf_r <= 1'b0;
    end

    // sticky event bits, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            istat_r <= '0;
        else
        begin
            for (int i = 0; i < `SSPM_IRQ_W; i++)
            begin
                if ((i == `SSPM_IRQ_DONE && done)
                    || (i == `SSPM_IRQ_COLL && coll))
                    istat_r[i] <= 1'b1;
                else if (wr_fire && paddr == `SSPM_ISTAT_OFS
                         && pwdata[i])
                    istat_r[i] <= 1'b0;
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(istat_r & imask_r);
    end

endmodule : sspm_top

// *** tb/sspm_top_asserts.sv ***
`timescale 1ns/1ps
module sspm_chk #(
    parameter int BITS = 8
) (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // serial side and power
    input wire sspm_pkg::sspm_pins_s spi_out,
    input wire logic                 sdi,
    input wire logic                 sleep_req,
    input wire logic                 irq
);
    import sspm_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rdy_wait;
        psel && $rose(penable) |-> !pready ##1 pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("pready not after one wait state");
    property p_rdy_acc;
        pready |-> psel && penable && $past(psel && penable);
    endproperty
    a_rdy_acc: assert property (p_rdy_acc)
        else $error("pready outside an access phase");
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("pready longer than one cycle");
    property p_rd_zero;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("prdata not zero outside pready");
    property p_err_map;
        pready |-> pslverr == (paddr > 12'h014);
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("pslverr does not match the map");
    property p_err_pulse;
        pslverr |-> pready;
    endproperty
    a_err_pulse: assert property (p_err_pulse)
        else $error("pslverr without pready");
    // two sync flops plus one margin cycle before the freeze must show
    property p_sleep_hold;
        sleep_req [*5] |-> $stable(spi_out.sck) && $stable(spi_out.sdo);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("serial pins moved during sleep");
    property p_sck_half;
        $changed(spi_out.sck) |=> $stable(spi_out.sck);
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("sck half period shorter than two cycles");
    // output enable only follows a control write, one or two cycles late
    property p_oe_ctrl;
        $changed(spi_out.sdo_oe) |->
            $past(pready && pwrite && paddr == 12'h000) ||
            $past(pready && pwrite && paddr == 12'h000, 2);
    endproperty
    a_oe_ctrl: assert property (p_oe_ctrl)
        else $error("sdo_oe changed without a control write");
endmodule : sspm_chk

bind sspm_top sspm_chk #(.BITS(BITS)) u_sspm_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_out(spi_out), .sdi(sdi),
    .sleep_req(sleep_req), .irq(irq));

// *** tb/sspm_slave.sv ***
`timescale 1ns/1ps
module sspm_slave (
    // master pins and bench setup
    input  wire logic       sck,
    input  wire logic       sdo,
    input  wire logic       edge_sel,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    // towards the master
    output logic            sdi,
    output logic [7:0]      rx_byte
);
    int n = 16;
    initial sdi = 1'b0;
    initial rx_byte = 8'h00;
    // counts sck toggles of one frame; no select pin, so load marks start
    always @(posedge load or sck)
    begin
        if (load)
        begin
            n = 0;
            sdi = tx_byte[7];
        end
        else if (n < 16)
        begin
            if (n[0] != edge_sel)
                rx_byte = {rx_byte[6:0], sdo};
            n = n + 1;
            // edge set ends the last bit on the last sck edge, so the line
            // goes bad there; edge clear has no such edge and holds the bit
            if (n < 16)
                sdi = tx_byte[7 - (edge_sel ? n / 2 : (n - 1) / 2)];
            else if (edge_sel)
                sdi = ~sdi;
        end
    end
endmodule : sspm_slave

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "sspm_map.svh"
module testbench;
    import sspm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        sleep_req = 1'b0;
    logic        load = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, sdi, irq, er;
    logic [7:0]  tx, stx, srx, per;
    sspm_ctrl_s  ctl = '0;
    sspm_pins_s  spi_out;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc;
    always #2.5 pclk = ~pclk;
    sspm_top u_sspm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spi_out(spi_out), .sdi(sdi), .sleep_req(sleep_req), .irq(irq));
    sspm_slave u_sspm_slave (.sck(spi_out.sck), .sdo(spi_out.sdo),
        .edge_sel(ctl.edge_sel), .load(load), .tx_byte(stx), .sdi(sdi),
        .rx_byte(srx));
    task automatic close_out();
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_near(input int got, input int exp, input int tol);
        check_count++;
        if (got < exp - tol || got > exp + tol)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_near
    // starts on a fresh edge, so back-to-back calls never reassign psel
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk
    function automatic int half(input logic [1:0] r, input int p);
        if (r == `SSPM_RATE_TMR)
            return (p + 1) * 4;
        return r == `SSPM_RATE_DIV4 ? 2 : (r == `SSPM_RATE_DIV16 ? 8 : 32);
    endfunction : half
    // one byte each way; slp sleeps that many cycles mid byte
    task automatic xfer(input int slp);
        int h;
        h = half(ctl.rate, per);
        tx = 8'($urandom);
        stx = 8'($urandom);
        @(posedge pclk);
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        chk({31'h0, spi_out.sck}, {31'h0, ctl.clock_idle_polarity});
        apb(1'b1, `SSPM_BUF_OFS, {24'h0, tx});
        cyc = 0;
        while (irq !== 1'b1 && cyc < 5000)
        begin
            @(posedge pclk);
            cyc++;
            sleep_req <= slp != 0 && cyc >= 20 && cyc < 20 + slp;
        end
        // timer phase at start is free running, so allow one half bit
        chk_near(cyc, 17 * h + 2 + slp, ctl.rate == 3 ? h : 0);
        if (ctl.sdo_en)
            chk({24'h0, srx}, {24'h0, tx});
        else
            chk({31'h0, spi_out.sdo_oe}, 32'h0000_0000);
        rdchk(`SSPM_STAT_OFS, 32'h0000_0001);
        rdchk(`SSPM_BUF_OFS, {24'h0, stx});
        rdchk(`SSPM_STAT_OFS, 32'h0000_0000);
        apb(1'b1, `SSPM_ISTAT_OFS, 32'h0000_0003);
        rdchk(`SSPM_ISTAT_OFS, 32'h0000_0000);
    endtask : xfer
    initial
    begin
        void'($urandom(54843));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`SSPM_CTRL_OFS, 32'h0000_0000);
        rdchk(`SSPM_PER_OFS, 32'h0000_0000);
        rdchk(`SSPM_STAT_OFS, 32'h0000_0000);
        rdchk(`SSPM_IMASK_OFS, 32'h0000_0000);
        apb(1'b1, 12'h018, 32'h0000_0001);
        chk({31'h0, er}, 32'h0000_0001);
        rdchk(12'h018, 32'h0000_0000);
        apb(1'b1, `SSPM_IMASK_OFS, 32'h0000_0003);
        // every rate, output edge and sample phase
        for (int m = 0; m < 16; m++)
        begin
            ctl = sspm_ctrl_s'(7'($urandom));
            ctl.en = 1'b1;
            ctl.rate = m[1:0];
            ctl.edge_sel = m[2];
            ctl.input_sample_phase = m[3];
            ctl.sdo_en = m != 6;
            per = 8'($urandom_range(3));
            apb(1'b1, `SSPM_PER_OFS, {24'h0, per});
            apb(1'b1, `SSPM_CTRL_OFS, {25'h0, ctl});
            xfer(m == 5 ? 50 : 0);
        end
        // a second write mid byte is refused and flagged
        apb(1'b1, `SSPM_IMASK_OFS, 32'h0000_0000);
        apb(1'b1, `SSPM_BUF_OFS, 32'h0000_00a5);
        apb(1'b1, `SSPM_BUF_OFS, 32'h0000_005a);
        rdchk(`SSPM_ISTAT_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `SSPM_IMASK_OFS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `SSPM_ISTAT_OFS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0000);
        close_out();
    end
    // about 4.5k cycles expected; 40k cuts a hang
    initial
    begin
        #200_000;
        n_errors++;
        close_out();
    end
endmodule : testbench
